/* common/emb_cfg.svh */
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH
// ==========================================
// Register word addresses
`define EMB_A_WRAP 8'h00
`define EMB_A_PACE 8'h01
`define EMB_A_MDIO 8'h02
`define EMB_A_ALIVE 8'h03
`define EMB_A_UACC 8'h04
`define EMB_A_URAW 8'h05
`define EMB_A_UMSET 8'h06
`define EMB_A_UMCLR 8'h07
`define EMB_A_USEL 8'h08
`define EMB_A_MAC 8'h09
`define EMB_A_RXC 8'h0A
`define EMB_A_TXC 8'h0B
`define EMB_A_RXMSET 8'h0C
`define EMB_A_RXMCLR 8'h0D
`define EMB_A_TXMSET 8'h0E
`define EMB_A_TXMCLR 8'h0F
`define EMB_A_MMSET 8'h10
`define EMB_A_MMCLR 8'h11
`define EMB_A_RXHP 8'h20
`define EMB_A_TXHP 8'h28
`define EMB_A_STAT 8'h40
// ==========================================
// Field positions
`define EMB_F_GIE 0
`define EMB_F_MDIV 15:0
`define EMB_F_PREOFF 20
`define EMB_F_MDEN 30
`define EMB_F_GO 31
`define EMB_F_UREG 25:21
`define EMB_F_UPHY 20:16
`define EMB_F_SELPHY 4:0
`define EMB_F_SELIE 6
`define EMB_F_MIIEN 5
`define EMB_F_DMAEN 0
`define EMB_F_VALID 0
// ==========================================
// Reset values and timing
`define EMB_RST_WORD 32'h0000_0000
`define EMB_CLK_NS 100
`define EMB_MDC_MIN_NS 1000
`define EMB_MDC_DIV ((`EMB_MDC_MIN_NS + 2 * `EMB_CLK_NS - 1) / (2 * `EMB_CLK_NS) - 1)
// ==========================================
// Management frame layout
`define EMB_POLL_REG 5'h01
`define EMB_CMD_HDR 4'h6
`define EMB_PRE_LAST 5'h1F
`define EMB_HDR_TOP 5'h0D
`define EMB_TA_FIRST 5'h0E
`define EMB_FLD_LAST 5'h0F
`define EMB_SCAN_LAST 5'h1F
`endif

/* common/emb_pkg.sv */
`default_nettype none
// ==========================================
// Shared types
package emb_pkg;
  // Management frame phase
  typedef enum logic [1:0] {
    MD_IDLE = 2'h0,
    MD_PRE = 2'h1,
    MD_CMD = 2'h2,
    MD_DATA = 2'h3
  } emb_mdst_e;
  // One register word
  typedef logic [31:0] emb_word_t;
endpackage : emb_pkg
`default_nettype wire

/* logic/emb_bringup.sv */
// How it works
// - Disabled peripheral ignores writes, reads zero
// - First enable loads all register defaults
// - Global enable; retrigger pacing on peripheral clock
// - Local 8K descriptor RAM
// - Enable off then on resets pacing
// - Divided management clock, 1 MHz at the reset divider
// - Engine enable and divider share one register
// - Preamble-suppress bit omits the preamble
// - Command-done and watched-PHY change interrupt enables
// - Engine polls all 32 PHY addresses
// - Presence map valid only after sweep
// - Eight transmit and eight receive queues
// - Writing zero clears each statistics counter
`timescale 1ns/1ps
`default_nettype none
`include "emb_cfg.svh"
module emb_bringup import emb_pkg::*; #(
  parameter int PACE_W = 16,
  parameter int DESC_WORDS = 2048,
  parameter int DESC_AW = 11,
  parameter int STAT_N = 36
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Peripheral enable from power control
  input wire logic periphEnable,
  // Host register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  // Descriptor RAM port
  input wire logic descWr,
  input wire logic descRd,
  input wire logic [DESC_AW-1:0] descAddr,
  input wire logic [31:0] descWrData,
  output logic [31:0] descRdData,
  // MAC events
  input wire logic [7:0] rxPend,
  input wire logic [7:0] txPend,
  input wire logic hostErr,
  input wire logic [STAT_N-1:0] statInc,
  // MAC controls
  output logic [31:0] macCtrl,
  output logic miiPortEnable,
  output logic rxDmaEnable,
  output logic txDmaEnable,
  output logic [7:0][31:0] rxHeadPtr,
  output logic [7:0][31:0] txHeadPtr,
  // Interrupt to the CPU
  output logic irqOut,
  // Management pins
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe_n
);
  // ==========================================
  // Enable sync and write decode
  logic enMeta_r, enS_r; // Enable synchroniser

  // Enable arrives from another block, so two flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enMeta_r <= 1'b0;
      enS_r <= 1'b0;
    end else begin
      enMeta_r <= periphEnable;
      enS_r <= enMeta_r;
    end
  end

  // Write hit; nothing lands while disabled
  function automatic logic hit(input logic [7:0] a);
    hit = regWr && enS_r && (regAddr == a);
  endfunction : hit

  // Mask update: set and clear registers
  function automatic logic [7:0] maskUpd(input logic [7:0] m, input logic [7:0] a, input logic [7:0] b);
    maskUpd = m;
    if (hit(a)) maskUpd = maskUpd | regWrData[7:0];
    if (hit(b)) maskUpd = maskUpd & ~regWrData[7:0];
  endfunction : maskUpd

  // ==========================================
  // Wrapper registers
  logic gie_r; // Global interrupt enable
  logic [PACE_W-1:0] pace_r; // Retrigger count
  emb_word_t mdioCtrl_r; // Engine enable, divider, preamble
  logic [31:0] mdioRst; // Divider default gives 1 MHz
  assign mdioRst = 32'(`EMB_MDC_DIV);

  // Disabled peripheral holds defaults, so first enable starts clean
  always_ff @(posedge clock) begin
    if (!rst_n || !enS_r) begin
      gie_r <= 1'b0;
      pace_r <= '0;
      mdioCtrl_r <= mdioRst;
    end else begin
      if (hit(`EMB_A_WRAP)) gie_r <= regWrData[`EMB_F_GIE];
      if (hit(`EMB_A_PACE)) pace_r <= regWrData[PACE_W-1:0];
      if (hit(`EMB_A_MDIO)) mdioCtrl_r <= regWrData;
    end
  end

  // ==========================================
  // Management user access and interrupts
  emb_word_t uAcc_r; // Go, register, PHY
  emb_word_t uSel_r; // Watched PHY and its enable
  logic [1:0] uRaw_r; // Done, PHY change
  logic uMask_r; // Done interrupt enable
  logic userDone, phyEvent, phyMapValid;
  logic [15:0] userData;
  logic [31:0] phyAliveMap;
  logic mdioIrq;

  always_ff @(posedge clock) begin
    if (!rst_n || !enS_r) begin
      uAcc_r <= `EMB_RST_WORD;
      uSel_r <= `EMB_RST_WORD;
      uRaw_r <= 2'h0;
      uMask_r <= 1'b0;
    end else begin
      if (hit(`EMB_A_UACC)) uAcc_r <= regWrData;
      else if (userDone) uAcc_r[`EMB_F_GO] <= 1'b0;
      if (hit(`EMB_A_USEL)) uSel_r <= regWrData;
      // Event beats a clear in the same cycle
      uRaw_r <= {phyEvent, userDone} | (uRaw_r & ~(hit(`EMB_A_URAW) ? regWrData[1:0] : 2'h0));
      if (hit(`EMB_A_UMSET) && regWrData[0]) uMask_r <= 1'b1;
      else if (hit(`EMB_A_UMCLR) && regWrData[0]) uMask_r <= 1'b0;
    end
  end

  assign mdioIrq = (uRaw_r[0] && uMask_r) || uRaw_r[1];

  // ==========================================
  // MAC control and queue heads
  emb_word_t rxCtrl_r, txCtrl_r;
  logic [7:0] rxMask_r, txMask_r;
  logic [7:0] macMask_r; // Bit 0 host error, bit 1 statistics

  always_ff @(posedge clock) begin
    if (!rst_n || !enS_r) begin
      macCtrl <= `EMB_RST_WORD;
      rxCtrl_r <= `EMB_RST_WORD;
      txCtrl_r <= `EMB_RST_WORD;
      rxMask_r <= 8'h00;
      txMask_r <= 8'h00;
      macMask_r <= 8'h00;
    end else begin
      if (hit(`EMB_A_MAC)) macCtrl <= regWrData;
      if (hit(`EMB_A_RXC)) rxCtrl_r <= regWrData;
      if (hit(`EMB_A_TXC)) txCtrl_r <= regWrData;
      rxMask_r <= maskUpd(rxMask_r, `EMB_A_RXMSET, `EMB_A_RXMCLR);
      txMask_r <= maskUpd(txMask_r, `EMB_A_TXMSET, `EMB_A_TXMCLR);
      macMask_r <= maskUpd(macMask_r, `EMB_A_MMSET, `EMB_A_MMCLR);
    end
  end

  // Port enable and DMA enables go straight to the MAC
  assign miiPortEnable = macCtrl[`EMB_F_MIIEN];
  assign rxDmaEnable = rxCtrl_r[`EMB_F_DMAEN];
  assign txDmaEnable = txCtrl_r[`EMB_F_DMAEN];

  // One head pointer per queue, each direction
  for (genvar q = 0; q < 8; q++) begin : g_head
    always_ff @(posedge clock) begin
      if (!rst_n || !enS_r) begin
        rxHeadPtr[q] <= `EMB_RST_WORD;
        txHeadPtr[q] <= `EMB_RST_WORD;
      end else begin
        if (hit(`EMB_A_RXHP + 8'(q))) rxHeadPtr[q] <= regWrData;
        if (hit(`EMB_A_TXHP + 8'(q))) txHeadPtr[q] <= regWrData;
      end
    end
  end

  // ==========================================
  // Statistics counters
  emb_word_t stat_r [STAT_N];
  logic [STAT_N-1:0] statHi; // Counter past half range

  // A write beats a count, so writing zero always clears
  for (genvar s = 0; s < STAT_N; s++) begin : g_stat
    always_ff @(posedge clock) begin
      if (!rst_n || !enS_r) begin
        stat_r[s] <= `EMB_RST_WORD;
      end else if (hit(`EMB_A_STAT + 8'(s))) begin
        stat_r[s] <= regWrData;
      end else if (statInc[s]) begin
        stat_r[s] <= stat_r[s] + 32'h0000_0001;
      end
    end
    assign statHi[s] = stat_r[s][31];
  end

  // ==========================================
  // Descriptor RAM, not cleared: software builds it
  emb_word_t descMem [DESC_WORDS];

  always_ff @(posedge clock) begin
    if (descWr && enS_r) begin
      descMem[descAddr] <= descWrData;
    end
  end

  // Read port, zero while disabled
  always_ff @(posedge clock) begin
    if (!rst_n || !enS_r) begin
      descRdData <= `EMB_RST_WORD;
    end else if (descRd) begin
      descRdData <= descMem[descAddr];
    end
  end

  // ==========================================
  // Register read mux
  emb_word_t rdNxt;

  always_comb begin
    rdNxt = `EMB_RST_WORD;
    unique case (regAddr)
      `EMB_A_WRAP: rdNxt[`EMB_F_GIE] = gie_r;
      `EMB_A_PACE: rdNxt[PACE_W-1:0] = pace_r;
      `EMB_A_MDIO: rdNxt = mdioCtrl_r;
      `EMB_A_ALIVE: rdNxt = phyMapValid ? phyAliveMap : `EMB_RST_WORD;
      `EMB_A_UACC: rdNxt = {uAcc_r[31:16], userData};
      `EMB_A_URAW: rdNxt[1:0] = uRaw_r;
      `EMB_A_UMSET: rdNxt[0] = uMask_r;
      `EMB_A_USEL: rdNxt = uSel_r;
      `EMB_A_MAC: rdNxt = macCtrl;
      `EMB_A_RXC: rdNxt = rxCtrl_r;
      `EMB_A_TXC: rdNxt = txCtrl_r;
      `EMB_A_RXMSET: rdNxt[7:0] = rxMask_r;
      `EMB_A_TXMSET: rdNxt[7:0] = txMask_r;
      `EMB_A_MMSET: rdNxt[7:0] = macMask_r;
      default: begin
        // Queue heads and counters by range
        for (int i = 0; i < 8; i++) begin
          if (regAddr == `EMB_A_RXHP + 8'(i)) rdNxt = rxHeadPtr[i];
          if (regAddr == `EMB_A_TXHP + 8'(i)) rdNxt = txHeadPtr[i];
        end
        for (int i = 0; i < STAT_N; i++) begin
          if (regAddr == `EMB_A_STAT + 8'(i)) rdNxt = stat_r[i];
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !enS_r) begin
      regRdData <= `EMB_RST_WORD;
    end else if (regRd) begin
      regRdData <= rdNxt;
    end
  end

  // ==========================================
  // Interrupt pacing and management engine
  logic irqReq;
  assign irqReq = |(rxPend & rxMask_r) || |(txPend & txMask_r) || (hostErr && macMask_r[0])
    || (|statHi && macMask_r[1]) || mdioIrq;

  emb_irq_pacer #(.PACE_W(PACE_W)) u_pacer (
    .clock(clock),
    .rst_n(rst_n),
    .globalIrqEnable(gie_r),
    .irqPaceCount(pace_r),
    .irqReq(irqReq),
    .irqOut(irqOut)
  );

  emb_mdio_poller u_poller (
    .clock(clock),
    .rst_n(rst_n),
    .mdioEnable(mdioCtrl_r[`EMB_F_MDEN]),
    .mdcDiv(mdioCtrl_r[`EMB_F_MDIV]),
    .preambleOff(mdioCtrl_r[`EMB_F_PREOFF]),
    .userPend(uAcc_r[`EMB_F_GO]),
    .userPhy(uAcc_r[`EMB_F_UPHY]),
    .userReg(uAcc_r[`EMB_F_UREG]),
    .watchPhy(uSel_r[`EMB_F_SELPHY]),
    .watchIrqEn(uSel_r[`EMB_F_SELIE]),
    .phyAliveMap(phyAliveMap),
    .phyMapValid(phyMapValid),
    .userDone(userDone),
    .userData(userData),
    .phyEvent(phyEvent),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe_n(mdioOe_n)
  );

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_off_read_zero: assert property (!enS_r |=> regRdData == 32'h0 && descRdData == 32'h0)
    else $error("read not zero while disabled");
  a_off_no_write: assert property (!enS_r && regWr |=> !gie_r && macCtrl == 32'h0)
    else $error("write landed while disabled");
  a_first_default: assert property ($rose(enS_r) |-> !gie_r && mdioCtrl_r == mdioRst && rxHeadPtr[0] == 32'h0)
    else $error("registers not at default on enable");
  a_user_set_wins: assert property (userDone && enS_r |=> uRaw_r[0])
    else $error("completion flag lost");
  a_stat_zero: assert property (regWr && enS_r && regAddr == `EMB_A_STAT && regWrData == 32'h0 |=> stat_r[0] == 32'h0)
    else $error("counter not cleared by zero write");
  c_bringup: cover property ($rose(miiPortEnable) ##[1:50] $rose(gie_r));
  c_map_valid: cover property ($rose(phyMapValid));
endmodule : emb_bringup
`default_nettype wire

/* logic/emb_irq_pacer.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_irq_pacer import emb_pkg::*; #(
  parameter int PACE_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic globalIrqEnable,
  input wire logic [PACE_W-1:0] irqPaceCount,
  // Event in, paced pulse out
  input wire logic irqReq,
  output logic irqOut
);
  // ==========================================
  // Pace counter
  logic [PACE_W-1:0] cnt_r; // Cycles left before retrigger
  logic irq_r; // Paced pulse
  logic irqFire; // Fire this cycle

  assign irqFire = globalIrqEnable && irqReq && (cnt_r == '0);

  // Counter reloads on each pulse; dropping the enable zeroes it
  always_ff @(posedge clock) begin
    if (!rst_n || !globalIrqEnable) begin
      cnt_r <= '0;
    end else if (irqFire) begin
      cnt_r <= irqPaceCount;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - PACE_W'(1);
    end
  end

  // Pulse register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irqFire;
    end
  end

  assign irqOut = irq_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_pace_gap: assert property (irq_r && $past(irqPaceCount) >= 2 && $past(globalIrqEnable) |-> ##1 !irq_r ##1 !irq_r)
    else $error("pulses closer than pace count");
  a_pace_restart: assert property (!globalIrqEnable ##1 (globalIrqEnable && irqReq) |=> irq_r)
    else $error("re-enable did not clear pacing");
  a_irq_gated: assert property (!$past(globalIrqEnable) |-> !irq_r)
    else $error("pulse while disabled");
  c_paced: cover property (irq_r ##[1:20] irq_r);
endmodule : emb_irq_pacer
`default_nettype wire

/* logic/emb_mdio_poller.sv */
`timescale 1ns/1ps
`default_nettype none
`include "emb_cfg.svh"
module emb_mdio_poller import emb_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic mdioEnable,
  input wire logic [15:0] mdcDiv,
  input wire logic preambleOff,
  input wire logic userPend,
  input wire logic [4:0] userPhy,
  input wire logic [4:0] userReg,
  input wire logic [4:0] watchPhy,
  input wire logic watchIrqEn,
  // Results
  output logic [31:0] phyAliveMap,
  output logic phyMapValid,
  output logic userDone,
  output logic [15:0] userData,
  output logic phyEvent,
  // Management pins
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe_n
);
  // ==========================================
  // Clock divider and input sync
  logic [15:0] divCnt_r; // Half-period counter
  logic mdc_r; // Management clock
  logic mdioMeta_r, mdioS_r; // Pin synchroniser
  logic tick, fallT, riseT;

  assign tick = (divCnt_r == mdcDiv);
  assign fallT = tick && mdc_r;
  assign riseT = tick && !mdc_r;

  // Clock runs at clock / (2 * (div + 1))
  always_ff @(posedge clock) begin
    if (!rst_n || !mdioEnable) begin
      divCnt_r <= 16'h0000;
      mdc_r <= 1'b0;
    end else if (tick) begin
      divCnt_r <= 16'h0000;
      mdc_r <= ~mdc_r;
    end else begin
      divCnt_r <= divCnt_r + 16'h0001;
    end
  end

  // Two flops before the pin is read
  always_ff @(posedge clock) begin
    mdioMeta_r <= mdioIn;
    mdioS_r <= mdioMeta_r;
  end

  // ==========================================
  // Frame sequencer, advances on falling edges
  emb_mdst_e st_r;
  logic [4:0] bit_r, phy_r, reg_r, scan_r;
  logic isUser_r, ack_r;
  logic [15:0] shift_r;
  logic endF;

  always_ff @(posedge clock) begin
    if (!rst_n || !mdioEnable) begin
      st_r <= MD_IDLE;
      bit_r <= 5'h00;
      phy_r <= 5'h00;
      reg_r <= 5'h00;
      isUser_r <= 1'b0;
    end else if (fallT) begin
      unique case (st_r)
        MD_IDLE: begin
          // User access jumps ahead of the scan
          isUser_r <= userPend;
          phy_r <= userPend ? userPhy : scan_r;
          reg_r <= userPend ? userReg : `EMB_POLL_REG;
          bit_r <= 5'h00;
          st_r <= preambleOff ? MD_CMD : MD_PRE;
        end
        MD_PRE: begin
          bit_r <= bit_r + 5'h01;
          if (bit_r == `EMB_PRE_LAST) begin
            bit_r <= 5'h00;
            st_r <= MD_CMD;
          end
        end
        MD_CMD: begin
          bit_r <= bit_r + 5'h01;
          if (bit_r == `EMB_FLD_LAST) begin
            bit_r <= 5'h00;
            st_r <= MD_DATA;
          end
        end
        MD_DATA: begin
          bit_r <= bit_r + 5'h01;
          if (bit_r == `EMB_FLD_LAST) begin
            st_r <= MD_IDLE;
          end
        end
      endcase
    end
  end

  // Sample on rising edges: ack in turnaround, then data
  always_ff @(posedge clock) begin
    if (!rst_n || !mdioEnable) begin
      ack_r <= 1'b0;
      shift_r <= 16'h0000;
    end else if (riseT) begin
      if (st_r == MD_CMD && bit_r == `EMB_FLD_LAST) begin
        ack_r <= !mdioS_r;
      end
      if (st_r == MD_DATA) begin
        shift_r <= {shift_r[14:0], mdioS_r};
      end
    end
  end

  assign endF = fallT && (st_r == MD_DATA) && (bit_r == `EMB_FLD_LAST);

  // Results; the map is trusted only after one full sweep
  always_ff @(posedge clock) begin
    if (!rst_n || !mdioEnable) begin
      phyAliveMap <= 32'h0000_0000;
      phyMapValid <= 1'b0;
      scan_r <= 5'h00;
      userDone <= 1'b0;
      phyEvent <= 1'b0;
      userData <= 16'h0000;
    end else begin
      userDone <= endF && isUser_r;
      phyEvent <= endF && !isUser_r && watchIrqEn && (phy_r == watchPhy) && (phyAliveMap[phy_r] != ack_r);
      if (endF && isUser_r) begin
        userData <= shift_r;
      end
      if (endF && !isUser_r) begin
        phyAliveMap[phy_r] <= ack_r;
        scan_r <= scan_r + 5'h01;
        if (scan_r == `EMB_SCAN_LAST) begin
          phyMapValid <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Pin drive: preamble and header, released from turnaround on
  logic drive;
  logic [4:0] cmdIdx;
  logic [13:0] cmdWord;
  assign cmdWord = {`EMB_CMD_HDR, phy_r, reg_r};
  assign cmdIdx = `EMB_HDR_TOP - bit_r;
  assign drive = (st_r == MD_PRE) || (st_r == MD_CMD && bit_r < `EMB_TA_FIRST);
  assign mdioOut = (st_r == MD_CMD) ? cmdWord[cmdIdx[3:0]] : 1'b1;
  assign mdioOe_n = !drive;
  assign mdc = mdc_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_pre_skip: assert property (st_r == MD_IDLE && fallT && preambleOff && mdioEnable |=> st_r == MD_CMD)
    else $error("preamble not skipped");
  a_mdc_div: assert property ($changed(mdc_r) && $past(mdioEnable) |-> $past(divCnt_r) == $past(mdcDiv))
    else $error("clock edge off divider");
  a_poll_next: assert property (endF && !isUser_r && mdioEnable |=> scan_r == $past(scan_r) + 5'h01)
    else $error("scan address did not advance");
  c_user_done: cover property (userDone);
endmodule : emb_mdio_poller
`default_nettype wire

/* tb/emb_bringup_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_bringup_tb;
  import emb_pkg::*;
  localparam logic [4:0] PHY = 5'h05;
  localparam logic [15:0] PDAT = 16'hC3A5;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic periphEnable = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] regRdData;
  logic descWr = 1'b0;
  logic descRd = 1'b0;
  logic [10:0] descAddr = 11'h0;
  logic [31:0] descWrData = 32'h0;
  logic [31:0] descRdData;
  logic hostErr = 1'b0;
  logic [35:0] statInc = 36'h0;
  logic miiPortEnable, rxDmaEnable, txDmaEnable, irqOut;
  logic [31:0] macCtrl;
  logic mdc, mdioOut, mdioOe_n, phyOe, phyOut, mdio, mdcQ;
  logic [7:0][31:0] rxHeadPtr, txHeadPtr;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int mdcCnt = 0;
  int mdcPer = 0;
  // =====
  // Clock, pull-up wire, watchdog
  always #50 clock = ~clock;
  assign mdio = !mdioOe_n ? mdioOut : (phyOe ? phyOut : 1'b1);
  always @(posedge clock) begin
    mdcQ <= mdc;
    cyc <= cyc + 1;
    mdcCnt <= (mdc && !mdcQ) ? 1 : mdcCnt + 1;
    if (mdc && !mdcQ) mdcPer <= mdcCnt;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end
  emb_bringup u_emb_bringup (.clock(clock), .rst_n(rst_n), .periphEnable(periphEnable),
    .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .descWr(descWr), .descRd(descRd), .descAddr(descAddr), .descWrData(descWrData),
    .descRdData(descRdData), .rxPend(8'h00), .txPend(8'h00), .hostErr(hostErr), .statInc(statInc),
    .macCtrl(macCtrl), .miiPortEnable(miiPortEnable), .rxDmaEnable(rxDmaEnable), .txDmaEnable(txDmaEnable),
    .rxHeadPtr(rxHeadPtr), .txHeadPtr(txHeadPtr), .irqOut(irqOut), .mdc(mdc), .mdioIn(mdio),
    .mdioOut(mdioOut), .mdioOe_n(mdioOe_n));
  emb_phy_model #(.PHY_ADDR(PHY), .RD_DATA(PDAT)) u_emb_phy_model (.mdc(mdc),
    .devOe_n(mdioOe_n), .mdio(mdio), .phyOe(phyOe), .phyOut(phyOut));
  // =====
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(posedge clock);
    #1 d = regRdData;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rc
  task automatic dwr(input logic [10:0] a, input logic [31:0] d);
    @(posedge clock);
    descWr <= 1'b1;
    descAddr <= a;
    descWrData <= d;
    @(posedge clock);
    descWr <= 1'b0;
  endtask : dwr
  task automatic drc(input logic [10:0] a, input logic [31:0] e);
    @(posedge clock);
    descRd <= 1'b1;
    descAddr <= a;
    @(posedge clock);
    descRd <= 1'b0;
    @(posedge clock);
    #1 chk(descRdData, e);
  endtask : drc
  task automatic waitIrq(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (irqOut !== 1'b1 && n < 50);
  endtask : waitIrq
  // =====
  // Scenarios
  task automatic t_dis();
    wr(8'h00, 32'h1);
    rc(8'h00, 32'h0);
    dwr(11'h005, 32'h1234_5678);
    drc(11'h005, 32'h0);
    @(posedge clock);
    periphEnable <= 1'b1;
    repeat (3) @(posedge clock);
    rc(8'h00, 32'h0);
    rc(8'h02, 32'h0000_0004);
    rc(8'h01, 32'h0);
    $display("done: disabled");
  endtask : t_dis
  task automatic t_regs();
    wr(8'h20, 32'h0000_1000);
    wr(8'h27, 32'h0000_1700);
    wr(8'h2F, 32'h0000_2F00);
    // Let the last write settle before looking at the ports
    #1;
    chk(rxHeadPtr[0], 32'h0000_1000);
    chk(rxHeadPtr[7], 32'h0000_1700);
    chk(txHeadPtr[7], 32'h0000_2F00);
    wr(8'h0A, 32'h1);
    wr(8'h0B, 32'h1);
    wr(8'h09, 32'h20);
    #1;
    chk({29'h0, miiPortEnable, rxDmaEnable, txDmaEnable}, 32'h7);
    chk(macCtrl, 32'h0000_0020);
    // Host setup words for registers outside this block must be harmless
    wr(8'h12, 32'h0000_00FF);
    rc(8'h12, 32'h0);
    rc(8'h09, 32'h20);
    rc(8'hFF, 32'h0);
    dwr(11'h000, 32'hA5A5_0001);
    dwr(11'h7FF, 32'h5A5A_07FF);
    drc(11'h000, 32'hA5A5_0001);
    drc(11'h7FF, 32'h5A5A_07FF);
    $display("done: registers");
  endtask : t_regs
  task automatic t_irq();
    int n;
    wr(8'h00, 32'h0);
    wr(8'h01, 32'h20);
    wr(8'h10, 32'h1);
    hostErr <= 1'b1;
    wr(8'h00, 32'h1);
    waitIrq(n);
    waitIrq(n);
    chk(32'(n), 32'h21);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    waitIrq(n);
    chk(32'(n), 32'h1);
    @(posedge clock);
    hostErr <= 1'b0;
    wr(8'h00, 32'h0);
    $display("done: interrupt");
  endtask : t_irq
  task automatic t_stat();
    @(posedge clock);
    statInc <= 36'h1;
    @(posedge clock);
    statInc <= 36'h0;
    rc(8'h40, 32'h1);
    wr(8'h40, 32'h0);
    rc(8'h40, 32'h0);
    $display("done: statistics");
  endtask : t_stat
  task automatic t_sweep(input logic pre);
    logic [31:0] d;
    int c;
    c = 0;
    wr(8'h02, {1'b0, 1'b1, 9'h0, pre, 4'h0, 16'h0004});
    do begin
      repeat (50) @(posedge clock);
      rd(8'h03, d);
      c += 53;
    end while (d === 32'h0 && c < 40000);
    chk(d, 32'h1 << PHY);
    chk({31'h0, c > 16000}, {31'h0, !pre});
    chk(32'(mdcPer), 32'h0000_000A);
    $display("done: sweep");
  endtask : t_sweep
  task automatic t_user();
    logic [31:0] d;
    int n;
    n = 0;
    wr(8'h04, {1'b1, 5'h0, 5'h02, PHY, 16'h0});
    do begin
      repeat (40) @(posedge clock);
      rd(8'h05, d);
      n++;
    end while (d[0] !== 1'b1 && n < 60);
    chk({31'h0, d[0]}, 32'h1);
    rd(8'h04, d);
    chk({16'h0, d[15:0]}, {16'h0, PDAT});
    wr(8'h05, 32'h1);
    rc(8'h05, 32'h0);
    wr(8'h02, 32'h4);
    rc(8'h03, 32'h0);
    $display("done: user access");
  endtask : t_user
  task automatic stop_test();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_dis();
    t_regs();
    t_irq();
    t_stat();
    t_sweep(1'b0);
    t_user();
    t_sweep(1'b1);
    stop_test();
  end
endmodule : emb_bringup_tb
`default_nettype wire

/* tb/emb_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// PHY that answers one address
module emb_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h05,
  parameter logic [15:0] RD_DATA = 16'hC3A5
) (
  input wire logic mdc,
  input wire logic devOe_n,
  input wire logic mdio,
  output logic phyOe,
  output logic phyOut
);
  logic [13:0] sh = '0;
  logic [4:0] cnt = '0;
  // Keep only bits the device drove
  always @(posedge mdc) begin
    sh <= devOe_n ? 14'h0 : {sh[12:0], mdio};
  end
  // Header for us starts the answer
  always @(negedge mdc) begin
    if (cnt == 5'd0) begin
      cnt <= (sh[13:5] == {4'h6, PHY_ADDR}) ? 5'd1 : 5'd0;
    end else begin
      cnt <= (cnt == 5'd19) ? 5'd0 : cnt + 5'd1;
    end
  end
  // Ack low on second turnaround bit, then data msb first
  assign phyOe = (cnt >= 5'd2) && (cnt <= 5'd18);
  assign phyOut = (cnt == 5'd2) ? 1'b0 : RD_DATA[4'(5'd18 - cnt)];
endmodule : emb_phy_model
`default_nettype wire
